//--- pkg/cidm_consts.vh
// Purpose: constants for the caller-id function select and data framing block
// Assumes: 125 MHz system clock, 1200 baud demodulated line data
// Notes:   included by hdl/cidm_mode_control.v and by the self-checking bench
//
// Overview of operation
// - both selects high: line fsk, word-ready pin
// - high one, low zero: hybrid tone, steering
// - high zero, low one: line tone, steering
// - both low: power down, or test
// - interface select picks bit stream or byte
// - buffered mode keeps the trailing stop bit
// - bit stream: sample strobe and byte-end strobe
// - no carrier means no data stream
// - power down stops amps, demod, tone, oscillator
// - fsk selected: tone detector powered down
// - tone selected: fsk demodulator powered down
// - fsk from line only; tone either input
// - receive 1200 baud serial fsk data
// - mark is one, space is zero
// - strip start; 8 reads byte, 9th stop
// - word ready low half bit; read clears
// - carrier flag active low, hold time, gates
`ifndef CIDM_CONSTS_VH
`define CIDM_CONSTS_VH

// ----------------------------------------------------------------------------
// timing
// ----------------------------------------------------------------------------
`define CIDM_CLK_HZ       125000000
`define CIDM_BAUD         1200
// sized to the 20-bit counters: clock over baud rounded down, its half, 1 ms of clock
`define CIDM_BIT_CYC      20'd104166
`define CIDM_HALF_CYC     20'd52083
`define CIDM_CD_HOLD_US   1000
`define CIDM_CD_HOLD_CYC  20'd125000

// ----------------------------------------------------------------------------
// register map
// ----------------------------------------------------------------------------
`define CIDM_CTRL_OFS     8'h00
`define CIDM_STAT_OFS     8'h04
`define CIDM_CTRL_RST     4'h0
`define CIDM_CTRL_OVR     0
`define CIDM_CTRL_FLO     1
`define CIDM_CTRL_FHI     2
`define CIDM_CTRL_IFS     3
`define CIDM_STAT_FN_LSB  0
`define CIDM_STAT_IFS     2
`define CIDM_STAT_CD      3
`define CIDM_STAT_PD      4
`define CIDM_STAT_WD_LSB  8

// ----------------------------------------------------------------------------
// function codes, {high select, low select}
// ----------------------------------------------------------------------------
`define CIDM_FN_OFF       2'h0
`define CIDM_FN_TONE_LINE 2'h1
`define CIDM_FN_TONE_HYB  2'h2
`define CIDM_FN_FSK       2'h3

`endif

//--- hdl/cidm_mode_control.v
// Purpose: function select, power gating and fsk data framing of a caller-id receiver
// Assumes: analog front end delivers demodulated bit, raw carrier and raw tone levels
// Notes:   registers over ahb-lite; read data captured in the address phase
`include "cidm_consts.vh"
`timescale 1ns/1ps
`default_nettype none

module cidm_mode_control #(
  parameter [19:0] BIT_CYC  = `CIDM_BIT_CYC,
  parameter [19:0] HALF_CYC = `CIDM_HALF_CYC,
  parameter [19:0] CD_HOLD  = `CIDM_CD_HOLD_CYC
) (
  input  wire        clk_i,
  input  wire        rst_i,
  input  wire        hsel_i,
  input  wire [31:0] haddr_i,
  input  wire [1:0]  htrans_i,
  input  wire        hwrite_i,
  input  wire [2:0]  hsize_i,
  input  wire [31:0] hwdata_i,
  input  wire        hready_i,
  output reg         hreadyout_o,
  output reg         hresp_o,
  output reg  [31:0] hrdata_o,
  input  wire        interface_mode_select_i,
  input  wire        function_select_high_i,
  input  wire        function_select_low_i,
  input  wire        fsk_bit_i,
  input  wire        carrier_raw_i,
  input  wire        tone_raw_i,
  input  wire        read_shift_clock_i,
  output reg         data_o,
  output reg         word_ready_or_tone_steer_n_o,
  output reg         carrier_present_n_o,
  output reg         bit_sample_o,
  output reg         byte_end_o,
  output reg         line_amp_en_o,
  output reg         hybrid_amp_en_o,
  output reg         fsk_en_o,
  output reg         tone_en_o,
  output reg         osc_en_o,
  output reg         tone_input_hybrid_o,
  output reg         test_mode_o
);

  // --------------------------------------------------------------------------
  // input synchronisers
  // --------------------------------------------------------------------------
  localparam [2:0] I_FLO = 3'd0;
  localparam [2:0] I_FHI = 3'd1;
  localparam [2:0] I_IFS = 3'd2;
  localparam [2:0] I_FSK = 3'd3;
  localparam [2:0] I_CAR = 3'd4;
  localparam [2:0] I_TON = 3'd5;
  localparam [2:0] I_RCK = 3'd6;

  wire [6:0] async_w;
  reg  [6:0] s1_q;
  reg  [6:0] s2_q;
  reg        rck_d_q;

  assign async_w = {read_shift_clock_i, tone_raw_i, carrier_raw_i, fsk_bit_i,
                    interface_mode_select_i, function_select_high_i,
                    function_select_low_i};

  genvar gi;
  generate
    for (gi = 0; gi < 7; gi = gi + 1) begin : g_sync
      always @(posedge clk_i) begin
        if (rst_i) begin
          s1_q[gi] <= 1'b0;
          s2_q[gi] <= 1'b0;
        end else begin
          s1_q[gi] <= async_w[gi];
          s2_q[gi] <= s1_q[gi];
        end
      end
    end
  endgenerate

  always @(posedge clk_i) begin
    if (rst_i) begin
      rck_d_q <= 1'b0;
    end else begin
      rck_d_q <= s2_q[I_RCK];
    end
  end

  wire rck_rise_w = s2_q[I_RCK] & ~rck_d_q;
  wire fsk_s_w    = s2_q[I_FSK];

  // --------------------------------------------------------------------------
  // function decode
  // --------------------------------------------------------------------------
  reg  [3:0] ctrl_q;
  wire       ovr_w   = ctrl_q[`CIDM_CTRL_OVR];
  wire       ifs_w   = ovr_w ? ctrl_q[`CIDM_CTRL_IFS] : s2_q[I_IFS];
  wire [1:0] fn_w    = ovr_w ? {ctrl_q[`CIDM_CTRL_FHI], ctrl_q[`CIDM_CTRL_FLO]}
                             : {s2_q[I_FHI], s2_q[I_FLO]};
  wire       fsk_on  = (fn_w == `CIDM_FN_FSK);
  wire       tone_on = (fn_w == `CIDM_FN_TONE_LINE) | (fn_w == `CIDM_FN_TONE_HYB);
  // power down only with interface select high, so bit stream users need all pins
  wire       pdown   = (fn_w == `CIDM_FN_OFF) & ifs_w;
  wire       testm   = (fn_w == `CIDM_FN_OFF) & ~ifs_w;

  always @(posedge clk_i) begin
    if (rst_i) begin
      line_amp_en_o       <= 1'b0;
      hybrid_amp_en_o     <= 1'b0;
      fsk_en_o            <= 1'b0;
      tone_en_o           <= 1'b0;
      osc_en_o            <= 1'b0;
      tone_input_hybrid_o <= 1'b0;
      test_mode_o         <= 1'b0;
    end else begin
      line_amp_en_o       <= fsk_on | (fn_w == `CIDM_FN_TONE_LINE);
      hybrid_amp_en_o     <= (fn_w == `CIDM_FN_TONE_HYB);
      fsk_en_o            <= fsk_on;
      tone_en_o           <= tone_on;
      osc_en_o            <= ~pdown;
      tone_input_hybrid_o <= (fn_w == `CIDM_FN_TONE_HYB);
      test_mode_o         <= testm;
    end
  end

  // --------------------------------------------------------------------------
  // carrier detect with hold-over
  // --------------------------------------------------------------------------
  reg        cd_q;
  reg [19:0] cd_cnt_q;

  always @(posedge clk_i) begin
    if (rst_i || !fsk_on) begin
      cd_q     <= 1'b0;
      cd_cnt_q <= 20'h00000;
    end else if (s2_q[I_CAR]) begin
      cd_q     <= 1'b1;
      cd_cnt_q <= 20'h00000;
    end else if (cd_q) begin
      // short gaps in the carrier are ridden over
      if (cd_cnt_q == CD_HOLD - 20'h00001) begin
        cd_q     <= 1'b0;
        cd_cnt_q <= 20'h00000;
      end else begin
        cd_cnt_q <= cd_cnt_q + 20'h00001;
      end
    end
  end

  wire rx_en = fsk_on & cd_q;

  // --------------------------------------------------------------------------
  // serial word receiver
  // --------------------------------------------------------------------------
  localparam [1:0] RX_IDLE  = 2'h0;
  localparam [1:0] RX_START = 2'h1;
  localparam [1:0] RX_DATA  = 2'h2;
  localparam [1:0] RX_STOP  = 2'h3;

  reg [1:0]  rx_st_q;
  reg [19:0] rx_cnt_q;
  reg [2:0]  rx_idx_q;
  reg [7:0]  rx_sh_q;
  reg [8:0]  word_q;
  reg        word_end;

  always @(posedge clk_i) begin
    if (rst_i || !rx_en) begin
      rx_st_q      <= RX_IDLE;
      rx_cnt_q     <= 20'h00000;
      rx_idx_q     <= 3'h0;
      rx_sh_q      <= 8'h00;
      bit_sample_o <= 1'b0;
      word_end     <= 1'b0;
    end else begin
      bit_sample_o <= 1'b0;
      word_end     <= 1'b0;
      case (rx_st_q)
        RX_IDLE: begin
          rx_cnt_q <= 20'h00000;
          if (!fsk_s_w) begin
            rx_st_q <= RX_START;
          end
        end
        RX_START: begin
          // start bit is checked mid-bit and then dropped
          if (rx_cnt_q == HALF_CYC - 20'h00001) begin
            rx_cnt_q <= 20'h00000;
            rx_idx_q <= 3'h0;
            rx_st_q  <= fsk_s_w ? RX_IDLE : RX_DATA;
          end else begin
            rx_cnt_q <= rx_cnt_q + 20'h00001;
          end
        end
        RX_DATA: begin
          if (rx_cnt_q == BIT_CYC - 20'h00001) begin
            rx_cnt_q     <= 20'h00000;
            rx_sh_q      <= {fsk_s_w, rx_sh_q[7:1]};
            bit_sample_o <= 1'b1;
            rx_idx_q     <= rx_idx_q + 3'h1;
            if (rx_idx_q == 3'h7) begin
              rx_st_q <= RX_STOP;
            end
          end else begin
            rx_cnt_q <= rx_cnt_q + 20'h00001;
          end
        end
        RX_STOP: begin
          if (rx_cnt_q == BIT_CYC - 20'h00001) begin
            rx_cnt_q <= 20'h00000;
            word_end <= 1'b1;
            rx_st_q  <= RX_IDLE;
          end else begin
            rx_cnt_q <= rx_cnt_q + 20'h00001;
          end
        end
        default: begin
          rx_st_q <= RX_IDLE;
        end
      endcase
    end
  end

  // --------------------------------------------------------------------------
  // word buffer, word ready and data pin
  // --------------------------------------------------------------------------
  reg [8:0]  buf_q;
  reg        wrdy_low_q;
  reg [19:0] wrdy_cnt_q;

  always @(posedge clk_i) begin
    if (rst_i) begin
      word_q     <= 9'h000;
      buf_q      <= 9'h000;
      byte_end_o <= 1'b0;
      data_o     <= 1'b1;
      wrdy_low_q <= 1'b0;
      wrdy_cnt_q <= 20'h00000;
    end else begin
      byte_end_o <= word_end;
      if (word_end) begin
        word_q <= {fsk_s_w, rx_sh_q};
        buf_q  <= {fsk_s_w, rx_sh_q};
      end else if (ifs_w && rck_rise_w) begin
        buf_q <= {1'b0, buf_q[8:1]};
      end
      if (!ifs_w) begin
        data_o <= rx_en ? fsk_s_w : 1'b1;
      end else if (rck_rise_w && !word_end) begin
        data_o <= buf_q[0];
      end
      if (word_end) begin
        wrdy_low_q <= 1'b1;
        wrdy_cnt_q <= 20'h00000;
      end else if (wrdy_low_q) begin
        // a read edge clears the request early in byte mode
        if ((ifs_w && rck_rise_w) || wrdy_cnt_q == HALF_CYC - 20'h00001) begin
          wrdy_low_q <= 1'b0;
        end
        wrdy_cnt_q <= wrdy_cnt_q + 20'h00001;
      end
    end
  end

  always @(posedge clk_i) begin
    if (rst_i) begin
      word_ready_or_tone_steer_n_o <= 1'b1;
      carrier_present_n_o          <= 1'b1;
    end else begin
      carrier_present_n_o <= ~cd_q;
      if (fsk_on) begin
        word_ready_or_tone_steer_n_o <= ~wrdy_low_q;
      end else if (tone_on) begin
        word_ready_or_tone_steer_n_o <= ~s2_q[I_TON];
      end else begin
        word_ready_or_tone_steer_n_o <= 1'b1;
      end
    end
  end

  // --------------------------------------------------------------------------
  // ahb-lite register slave
  // --------------------------------------------------------------------------
  reg       wr_pend_q;
  reg [7:0] wr_addr_q;
  wire      ahb_go = hsel_i & hready_i & htrans_i[1];

  always @(posedge clk_i) begin
    if (rst_i) begin
      hreadyout_o <= 1'b1;
      hresp_o     <= 1'b0;
      hrdata_o    <= 32'h00000000;
      wr_pend_q   <= 1'b0;
      wr_addr_q   <= 8'h00;
      ctrl_q      <= `CIDM_CTRL_RST;
    end else begin
      hreadyout_o <= 1'b1;
      hresp_o     <= 1'b0;
      // only the low page decodes, so aliases above it are ignored
      wr_pend_q   <= ahb_go & hwrite_i & (haddr_i[31:8] == 24'h000000);
      if (ahb_go) begin
        wr_addr_q <= haddr_i[7:0];
      end
      if (ahb_go && !hwrite_i) begin
        hrdata_o <= 32'h00000000;
        if (haddr_i[31:8] == 24'h000000 && haddr_i[7:0] == `CIDM_CTRL_OFS) begin
          hrdata_o[3:0] <= ctrl_q;
        end else if (haddr_i[31:8] == 24'h000000 && haddr_i[7:0] == `CIDM_STAT_OFS) begin
          hrdata_o[`CIDM_STAT_FN_LSB+1:`CIDM_STAT_FN_LSB] <= fn_w;
          hrdata_o[`CIDM_STAT_IFS]                       <= ifs_w;
          hrdata_o[`CIDM_STAT_CD]                        <= cd_q;
          hrdata_o[`CIDM_STAT_PD]                        <= pdown;
          hrdata_o[`CIDM_STAT_WD_LSB+8:`CIDM_STAT_WD_LSB] <= word_q;
        end
      end
      if (wr_pend_q && wr_addr_q == `CIDM_CTRL_OFS) begin
        ctrl_q <= hwdata_i[3:0];
      end
    end
  end

endmodule // cidm_mode_control

`default_nettype wire

//--- test/cidm_chk_sva.sv
// Purpose: port checker for cidm_mode_control
// Assumes: bench parameters, enables settle in step
// Notes:   bound to the design after endmodule
`timescale 1ns/1ps
`default_nettype none
module cidm_chk #(
  parameter [19:0] BIT_CYC  = 64,
  parameter [19:0] HALF_CYC = 32,
  parameter [19:0] CD_HOLD  = 40
) (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic word_ready_or_tone_steer_n_o,
  input wire logic carrier_present_n_o,
  input wire logic bit_sample_o,
  input wire logic byte_end_o,
  input wire logic line_amp_en_o,
  input wire logic hybrid_amp_en_o,
  input wire logic fsk_en_o,
  input wire logic tone_en_o,
  input wire logic osc_en_o,
  input wire logic tone_input_hybrid_o,
  input wire logic test_mode_o
);
  // ---
  // properties
  // ---
  default clocking @(posedge clk_i); endclocking
  default disable iff (rst_i);
  logic [3:0] n_q;
  // an aborted word must not leak its count into the next one
  always_ff @(posedge clk_i)
    if (rst_i || byte_end_o || carrier_present_n_o) n_q <= 4'h0;
    else if (bit_sample_o) n_q <= n_q + 4'h1;
  a_fsk_no_tone: assert property (fsk_en_o |-> !tone_en_o)
    else $error("tone powered in fsk");
  a_pd_all_off: assert property (!osc_en_o && !test_mode_o |->
    !(line_amp_en_o | hybrid_amp_en_o | fsk_en_o | tone_en_o))
    else $error("block on in power down");
  a_fsk_line: assert property (fsk_en_o |-> line_amp_en_o)
    else $error("fsk without line amp");
  a_tone_route: assert property (tone_en_o |->
    (tone_input_hybrid_o ? hybrid_amp_en_o : line_amp_en_o))
    else $error("tone input amp off");
  a_word_bits: assert property (byte_end_o |-> n_q == 4'h8)
    else $error("byte end without 8 samples");
  a_ready_low: assert property (byte_end_o && fsk_en_o |=>
    !word_ready_or_tone_steer_n_o)
    else $error("no word ready at byte end");
  a_ready_rel: assert property ($fell(word_ready_or_tone_steer_n_o) && fsk_en_o
    |-> ##[1:40] word_ready_or_tone_steer_n_o)
    else $error("word ready stuck low");
  a_end_pulse: assert property (byte_end_o |=> !byte_end_o)
    else $error("byte end longer than one cycle");
  a_smp_carrier: assert property (bit_sample_o |-> !carrier_present_n_o)
    else $error("sample without carrier");
endmodule // cidm_chk
bind cidm_mode_control cidm_chk #(.BIT_CYC(BIT_CYC), .HALF_CYC(HALF_CYC), .CD_HOLD(CD_HOLD))
  u_chk (.clk_i, .rst_i, .word_ready_or_tone_steer_n_o, .carrier_present_n_o, .bit_sample_o,
  .byte_end_o, .line_amp_en_o, .hybrid_amp_en_o, .fsk_en_o, .tone_en_o, .osc_en_o,
  .tone_input_hybrid_o, .test_mode_o);
`default_nettype wire

//--- test/cidm_host.sv
// Purpose: host side, shifts the buffered word out with the read clock
// Assumes: 80 ns read clock, idle low between frames
// Notes:   phase unrelated to the system clock
`timescale 1ns/1ps
`default_nettype none
module cidm_host (
  input  wire logic       go_i,
  input  wire logic       data_i,
  output var  logic       rsc_o,
  output var  logic [8:0] got_o,
  output var  logic       done_o
);
  // ---
  // read frame: 8 byte pulses, 9th gives the stop bit
  // ---
  initial begin
    rsc_o = 1'b0;
    got_o = 9'h0;
    done_o = 1'b0;
    forever begin
      wait (go_i);
      #3;
      for (int i = 0; i < 9; i++) begin
        rsc_o = 1'b1;
        #40;
        rsc_o = 1'b0;
        #40;
        got_o[i] = data_i;
      end
      done_o = 1'b1;
      wait (!go_i);
      done_o = 1'b0;
    end
  end
endmodule // cidm_host
`default_nettype wire

//--- test/tb.sv
// Purpose: self-checking bench for cidm_mode_control
// Assumes: bit 64, half 32, carrier hold 40 cycles
// Notes:   random bytes and tone levels from an lfsr
`include "cidm_consts.vh"
`timescale 1ns/1ps
`default_nettype none
`define CHK(s, e, g) begin comparisons++; if ((g) !== (e)) begin miscompares++; \
  $display("[FAIL] %s exp %h got %h", s, e, g); end end
module tb;
  logic clk_i = 0, rst_i = 1, hsel_i = 0, hwrite_i = 0, ifs = 1, fhi = 1, flo = 1, fsk = 1;
  logic car = 0, tone = 0, go = 0, rdy, hresp, dat, wr_n, cd_n, smp, bend, rsc, done;
  logic la, ha, fe, te, oe, th, tm;
  logic [1:0] htrans_i = 0;
  logic [31:0] haddr_i = 0, hwdata_i = 0, hrdata, rd, r = 32'h432a;
  logic [8:0] got;
  logic [7:0] byt;
  int miscompares = 0, comparisons = 0, n, k;
  cidm_mode_control #(.BIT_CYC(20'd64), .HALF_CYC(20'd32), .CD_HOLD(20'd40)) i_dut (
    .clk_i, .rst_i, .hsel_i, .haddr_i, .htrans_i, .hwrite_i, .hsize_i(3'h2), .hwdata_i,
    .hready_i(rdy), .hreadyout_o(rdy), .hresp_o(hresp), .hrdata_o(hrdata),
    .interface_mode_select_i(ifs), .function_select_high_i(fhi), .function_select_low_i(flo),
    .fsk_bit_i(fsk), .carrier_raw_i(car), .tone_raw_i(tone), .read_shift_clock_i(rsc),
    .data_o(dat), .word_ready_or_tone_steer_n_o(wr_n), .carrier_present_n_o(cd_n),
    .bit_sample_o(smp), .byte_end_o(bend), .line_amp_en_o(la), .hybrid_amp_en_o(ha),
    .fsk_en_o(fe), .tone_en_o(te), .osc_en_o(oe), .tone_input_hybrid_o(th), .test_mode_o(tm));
  cidm_host u_host (.go_i(go), .data_i(dat), .rsc_o(rsc), .got_o(got), .done_o(done));
  initial forever #4 clk_i = ~clk_i;
  // ---
  // helpers
  // ---
  function automatic logic [31:0] lfsr(input logic [31:0] x);
    return {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
  endfunction
  task automatic print_verdict;
    $display("miscompares %0d comparisons %0d", miscompares, comparisons);
    if (miscompares == 0 && comparisons > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask
  task automatic wait_rdy;
    n = 0;
    do begin @(posedge clk_i); n++; end while (rdy !== 1'b1 && n < 50);
    if (rdy !== 1'b1) begin miscompares++; print_verdict; end
  endtask
  // address phase held until hready, then data phase until hready again
  task automatic ahb(input logic w, input logic [31:0] a, input logic [31:0] d);
    hsel_i <= 1'b1; htrans_i <= 2'h2; haddr_i <= a; hwrite_i <= w;
    wait_rdy;
    htrans_i <= 2'h0; hwdata_i <= d;
    wait_rdy;
    rd = hrdata;
    `CHK("resp", 1'b0, hresp)
    hsel_i <= 1'b0;
    @(posedge clk_i);
  endtask
  task automatic send(input logic [7:0] b);
    logic [9:0] f;
    f = {1'b1, b, 1'b0};
    for (int i = 0; i < 10; i++) begin fsk <= f[i]; repeat (64) @(posedge clk_i); end
  endtask
  task automatic mon;
    k = 0;
    repeat (2000) begin
      @(posedge clk_i);
      if (smp === 1'b1) begin byt = {dat, byt[7:1]}; k++; end
      if (bend === 1'b1) break;
    end
    if (bend !== 1'b1) begin miscompares++; print_verdict; end
  endtask
  task automatic word(input logic mode);
    {ifs, fhi, flo} <= {mode, 2'h3};
    car <= 1'b1;
    r = lfsr(r);
    repeat (8) @(posedge clk_i);
    `CHK("carrier", 1'b0, cd_n)
    fork send(r[7:0]); mon; join
    `CHK("samples", 8, k)
    if (!mode) `CHK("stream", r[7:0], byt)
  endtask
  // ---
  // main sequence
  // ---
  initial begin
    repeat (3) @(posedge clk_i);
    rst_i <= 1'b0;
    repeat (6) @(posedge clk_i);
    `CHK("idle", 4'hf, {rdy, wr_n, cd_n, dat})
    for (int c = 0; c < 8; c++) begin
      r = lfsr(r);
      {ifs, fhi, flo} <= c[2:0];
      tone <= r[0];
      repeat (8) @(posedge clk_i);
      `CHK("test", c == 0, tm)
      if (c != 0) begin
        `CHK("power", {&c[1:0], ^c[1:0], c[0], c[1:0] == 2, c != 4}, {fe, te, la, ha, oe})
        `CHK("steer", ^c[1:0] ? ~r[0] : 1'b1, wr_n)
        if (^c[1:0]) `CHK("source", c[1:0] == 2, th)
      end
    end
    word(1'b0);
    word(1'b1);
    go <= 1'b1;
    repeat (12) @(posedge clk_i);
    `CHK("ready", 1'b1, wr_n)
    for (n = 0; n < 300 && done !== 1'b1; n++) @(posedge clk_i);
    if (done !== 1'b1) begin miscompares++; print_verdict; end
    `CHK("buffer", {1'b1, r[7:0]}, got)
    go <= 1'b0;
    {car, fsk, ifs} <= 3'h0;
    repeat (10) @(posedge clk_i);
    `CHK("hold", 1'b0, cd_n)
    repeat (50) @(posedge clk_i);
    `CHK("gated", 2'h3, {cd_n, dat})
    ahb(1'b1, {24'h0, `CIDM_CTRL_OFS}, 32'hd);
    repeat (8) @(posedge clk_i);
    ahb(1'b0, {24'h0, `CIDM_STAT_OFS}, 32'h0);
    `CHK("status", 4'he, {th, rd[2:0]})
    ahb(1'b0, 32'h40, 32'h0);
    `CHK("unmapped", 32'h0, rd)
    ahb(1'b1, {24'h0, `CIDM_CTRL_OFS}, 32'h0);
    print_verdict;
  end
endmodule // tb
`default_nettype wire
